// file: pcoc_cfg.svh
// constants for the phase count and offset configuration block
`ifndef PCOC_CFG_SVH
`define PCOC_CFG_SVH
`define PCOC_ADDR_W          8
`define PCOC_OFFSET_CFG_ADDR 8'h0e
`define PCOC_OFFSET_CFG_RST  8'h00
`define PCOC_OFS_EN_BIT      5
`define PCOC_OFS_MAG_HI      4
`define PCOC_OFS_MAG_LO      0
`define PCOC_OFS_POL_BIT     6
`define PCOC_CBG_ADDR_BASE   8'h40
`define PCOC_CBG_RST         5'h0f
`define PCOC_MAX_CNT_ADDR    8'h48
`define PCOC_PH_CNT_MIN      4'h1
`define PCOC_NUM_PHASES      8
`define PCOC_PH_CNT_MAX      4'h8
`endif

// file: pcoc_pkg.sv
// types for the phase count and offset configuration block
package pcoc_pkg;
   // detect sequence states
   typedef enum logic [2:0] {
      PCOC_IDLE   = 3'b001,
      PCOC_SAMPLE = 3'b010,
      PCOC_DONE   = 3'b100
   } pcoc_state_e;
   typedef logic [3:0] pcoc_cnt_t;
endpackage

// file: pcoc_top.sv
// phase count detection, offset current control and balance gain registers
`timescale 1ns/10ps
`include "pcoc_cfg.svh"
module pcoc_top
   import pcoc_pkg::*;
(
   input  wire logic        mclk,              // 100 mhz clock
   input  wire logic        resetn,            // async reset, active low
   input  wire logic        reg_wr,            // register write strobe
   input  wire logic        reg_rd,            // register read strobe
   input  wire logic [7:0]  reg_addr,          // register address
   input  wire logic [7:0]  reg_wdata,         // register write data
   output logic      [7:0]  reg_rdata,         // register read data
   input  wire logic        detect_start,      // pin-setting detection event
   input  wire logic [7:0]  sense_above_thr,   // comparator: input > vcc-0.5v
   input  wire logic [3:0]  req_phase_cnt,     // requested count, pin or reg
   output logic      [3:0]  max_phase_cnt,     // latched hardware limit
   output logic      [3:0]  active_phase_cnt,  // clamped operating count
   output logic      [7:0]  phase_disabled,    // per phase disable flags
   output logic             offset_source_en,  // current out of feedback pin
   output logic             offset_sink_en,    // current into feedback pin
   output logic      [4:0]  offset_magnitude,  // offset current code
   output logic      [39:0] current_balance_gain // 5 bits per phase
);

   // ***************************************************************
   // reset and input synchronisers
   // ***************************************************************
   logic       rst_s1_q;
   logic       rst_n;
   logic [7:0] sen_s1_q;
   logic [7:0] sen_s2_q;
   logic       det_s1_q;
   logic       det_s2_q;
   logic       det_s3_q;

   // reset release through two flops
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   // comparator levels and detect event come from analog, so sync them
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sen_s1_q <= 8'h00;
         sen_s2_q <= 8'h00;
         det_s1_q <= 1'b0;
         det_s2_q <= 1'b0;
         det_s3_q <= 1'b0;
      end
      else
      begin
         sen_s1_q <= sense_above_thr;
         sen_s2_q <= sen_s1_q;
         det_s1_q <= detect_start;
         det_s2_q <= det_s1_q;
         det_s3_q <= det_s2_q;
      end
   end

   wire det_rise = det_s2_q & ~det_s3_q;  // edge taken after second flop

   // ***************************************************************
   // register file
   // ***************************************************************
   logic [7:0]  ofs_cfg_q;
   logic [7:0]  ofs_cfg_d;
   logic [39:0] cbg_q;
   logic [39:0] cbg_d;
   logic [7:0]  rdata_q;
   logic [7:0]  rdata_d;

   // write decode; gain registers sit at consecutive addresses
   always_comb
   begin
      ofs_cfg_d = ofs_cfg_q;
      cbg_d     = cbg_q;
      rdata_d   = rdata_q;
      if (reg_wr && reg_addr == `PCOC_OFFSET_CFG_ADDR)
         ofs_cfg_d = reg_wdata;
      for (int i = 0; i < `PCOC_NUM_PHASES; i++)
         if (reg_wr && reg_addr == `PCOC_CBG_ADDR_BASE + 8'(i))
            cbg_d[i*5 +: 5] = reg_wdata[4:0];
      if (reg_rd)
      begin
         rdata_d = 8'h00;  // unmapped reads return zero
         if (reg_addr == `PCOC_OFFSET_CFG_ADDR)
            rdata_d = ofs_cfg_q;
         for (int i = 0; i < `PCOC_NUM_PHASES; i++)
            if (reg_addr == `PCOC_CBG_ADDR_BASE + 8'(i))
               rdata_d = {3'h0, cbg_q[i*5 +: 5]};
         // read-only copy of the latched limit, writes here are dropped
         if (reg_addr == `PCOC_MAX_CNT_ADDR)
            rdata_d = {4'h0, max_phase_cnt};
      end
   end

   // register storage
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ofs_cfg_q <= `PCOC_OFFSET_CFG_RST;
         cbg_q     <= {`PCOC_NUM_PHASES{`PCOC_CBG_RST}};
         rdata_q   <= 8'h00;
      end
      else
      begin
         ofs_cfg_q <= ofs_cfg_d;
         cbg_q     <= cbg_d;
         rdata_q   <= rdata_d;
      end
   end

   assign reg_rdata            = rdata_q;
   assign current_balance_gain = cbg_q;

   // ***************************************************************
   // offset current control
   // ***************************************************************
   logic       src_q;
   logic       snk_q;
   logic [4:0] mag_q;
   logic       src_d;
   logic       snk_d;
   logic [4:0] mag_d;

   // polarity bit one asks for positive offset, which means sinking
   always_comb
   begin
      src_d = 1'b0;
      snk_d = 1'b0;
      mag_d = 5'h00;
      if (ofs_cfg_q[`PCOC_OFS_EN_BIT])
      begin
         src_d = ~ofs_cfg_q[`PCOC_OFS_POL_BIT];
         snk_d = ofs_cfg_q[`PCOC_OFS_POL_BIT];
         mag_d = ofs_cfg_q[`PCOC_OFS_MAG_HI:`PCOC_OFS_MAG_LO];
      end
   end

   // registered so the analog switches never see a decode glitch
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         src_q <= 1'b0;
         snk_q <= 1'b0;
         mag_q <= 5'h00;
      end
      else
      begin
         src_q <= src_d;
         snk_q <= snk_d;
         mag_q <= mag_d;
      end
   end

   assign offset_source_en = src_q;
   assign offset_sink_en   = snk_q;
   assign offset_magnitude = mag_q;

   // ***************************************************************
   // phase count detection
   // ***************************************************************
   pcoc_state_e st_q;
   pcoc_state_e st_d;
   pcoc_cnt_t   max_q;
   pcoc_cnt_t   max_d;
   logic [7:0]  dis_q;
   logic [7:0]  dis_d;
   pcoc_cnt_t   act_q;
   pcoc_cnt_t   act_d;

   // one sample per event; eight phases until the first detection
   always_comb
   begin
      st_d  = st_q;
      max_d = max_q;
      dis_d = dis_q;
      case (st_q)
         PCOC_IDLE:
            if (det_rise)
               st_d = PCOC_SAMPLE;
         PCOC_SAMPLE:
         begin
            dis_d = {sen_s2_q[7:1], 1'b0};
            // lowest pulled input n+1 gives n
            max_d = `PCOC_PH_CNT_MAX;
            for (int i = `PCOC_NUM_PHASES - 1; i >= 1; i--)
               if (sen_s2_q[i])
                  max_d = 4'(i);
            st_d = PCOC_DONE;
         end
         PCOC_DONE:
            if (!det_s2_q)
               st_d = PCOC_IDLE;
         default:
            st_d = PCOC_IDLE;
      endcase
      if (req_phase_cnt == 4'h0)
         act_d = `PCOC_PH_CNT_MIN;
      else if (req_phase_cnt > max_q)
         act_d = max_q;
      else
         act_d = req_phase_cnt;
   end

   // detection state and latched limit
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q  <= PCOC_IDLE;
         max_q <= `PCOC_PH_CNT_MAX;
         dis_q <= 8'h00;
         act_q <= `PCOC_PH_CNT_MIN;
      end
      else
      begin
         st_q  <= st_d;
         max_q <= max_d;
         dis_q <= dis_d;
         act_q <= act_d;
      end
   end

   assign max_phase_cnt    = max_q;
   assign phase_disabled   = dis_q;
   assign active_phase_cnt = act_q;

endmodule

// file: pcoc_top_monitor.sv
// assertion checker on the pcoc_top ports
`timescale 1ns/10ps
module pcoc_top_monitor
   import pcoc_pkg::*;
(
   input wire logic       mclk,             // clock
   input wire logic       resetn,           // reset
   input wire logic       reg_wr,           // write
   input wire logic [7:0] reg_addr,         // address
   input wire logic [7:0] reg_wdata,        // data
   input wire logic       detect_start,     // detect
   input wire logic [3:0] max_phase_cnt,    // limit
   input wire logic [3:0] active_phase_cnt, // count
   input wire logic [7:0] phase_disabled,   // flags
   input wire logic       offset_source_en, // source
   input wire logic       offset_sink_en,   // sink
   input wire logic [4:0] offset_magnitude  // code
);
   // ***************
   // properties
   // ***************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   // offset writes; outputs follow two edges later
   wire logic wr_ofs = reg_wr && reg_addr == 8'h0e;
   wire logic on_w   = wr_ofs && reg_wdata[5];
   property p_mag;
      on_w |-> ##2 offset_magnitude == $past(reg_wdata[4:0], 2);
   endproperty
   a_mag: assert property (p_mag) else $error("offset code");
   property p_pol;
      on_w |-> ##2 offset_sink_en == $past(reg_wdata[6], 2)
         && offset_source_en != offset_sink_en;
   endproperty
   a_pol: assert property (p_pol) else $error("offset polarity");
   property p_off;
      wr_ofs && !reg_wdata[5] |-> ##2 !offset_source_en && !offset_sink_en;
   endproperty
   a_off: assert property (p_off) else $error("offset not off");
   property p_idle;
      !offset_source_en && !offset_sink_en |-> offset_magnitude == 5'h00;
   endproperty
   a_idle: assert property (p_idle) else $error("idle current");
   // active lags max by one edge, so compare with the old limit
   property p_clamp;
      active_phase_cnt <= $past(max_phase_cnt) && active_phase_cnt != 4'h0;
   endproperty
   a_clamp: assert property (p_clamp) else $error("count clamp");
   property p_lim;
      max_phase_cnt inside {[4'h1:4'h8]} && !phase_disabled[0];
   endproperty
   a_lim: assert property (p_lim) else $error("limit range");
   property p_first;
      (phase_disabled & ~(8'hff << max_phase_cnt)) == 8'h00
         && (max_phase_cnt == 4'h8 || phase_disabled[max_phase_cnt[2:0]]);
   endproperty
   a_first: assert property (p_first) else $error("limit flags");
   property p_latch;
      $changed(max_phase_cnt) |-> $past(detect_start, 3);
   endproperty
   a_latch: assert property (p_latch) else $error("limit moved");
   cover property (on_w && reg_wdata[6]);
   cover property ($changed(max_phase_cnt));
   cover property (active_phase_cnt < max_phase_cnt);
endmodule
bind pcoc_top pcoc_top_monitor i_pcoc_top_monitor (.mclk, .resetn, .reg_wr,
   .reg_addr, .reg_wdata, .detect_start, .max_phase_cnt, .active_phase_cnt,
   .phase_disabled, .offset_source_en, .offset_sink_en, .offset_magnitude);

// file: pcoc_phase_model.sv
// power stage model setting the phase count straps
`timescale 1ns/10ps
module pcoc_phase_model
(
   input  wire logic       mclk,   // clock
   input  wire logic [3:0] phases, // fitted phases, 1 to 8
   output logic      [7:0] sense   // comparator outputs
);
   // floating inputs wander, so they toggle rather than hold
   logic flt_q = 1'b0;
   always @(posedge mclk)
      flt_q <= ~flt_q;
   // strap n+1 only, never the first
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         sense[i] = (i == int'(phases)) ? 1'b1 : (i > int'(phases)) && flt_q;
   end
endmodule

// file: pcoc_top_tb_top.sv
// self-checking bench for pcoc_top
`timescale 1ns/10ps
`define CHK(n, g, e) begin checks_done++; if ((g) !== (e)) begin \
   err_total++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); \
   end end
module pcoc_top_tb_top;
   logic        mclk, resetn, reg_wr, reg_rd, detect_start;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, sense_above_thr;
   logic [7:0]  phase_disabled, mk, ex;
   logic [3:0]  req_phase_cnt, max_phase_cnt, active_phase_cnt, phases;
   logic        offset_source_en, offset_sink_en;
   logic [4:0]  offset_magnitude, g;
   logic [6:0]  ofs_out;
   logic [39:0] current_balance_gain, gx;
   logic [14:0] ot [6] = '{{8'h25, 7'h45}, {8'h7f, 7'h3f}, {8'h00, 7'h00},
                          {8'h1f, 7'h00}, {8'h60, 7'h20}, {8'h45, 7'h00}};
   int          err_total, checks_done, cyc;
   pcoc_top i_pcoc_top (.mclk, .resetn, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .detect_start, .sense_above_thr,
      .req_phase_cnt, .max_phase_cnt, .active_phase_cnt, .phase_disabled,
      .offset_source_en, .offset_sink_en, .offset_magnitude,
      .current_balance_gain);
   pcoc_phase_model i_pcoc_phase_model (.mclk, .phases,
      .sense(sense_above_thr));
   // offset pins gathered so one compare covers polarity and code
   assign ofs_out = {offset_source_en, offset_sink_en, offset_magnitude};
   // ***************
   // tasks
   // ***************
   task automatic end_sim(input int late);
      err_total += late;
      if (err_total == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // inputs move 1 ns after the edge, clear of sampling races
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      tick(1);
      reg_wr = 1'b0;
      tick(2);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_rd = 1'b1;
      reg_addr = a;
      tick(1);
      reg_rd = 1'b0;
      tick(1);
      `CHK("reg_rdata", reg_rdata, e)
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // hang guard
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 3000)
         end_sim(1);
   end
   initial
   begin
      {resetn, reg_wr, reg_rd, detect_start} = 4'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      req_phase_cnt = 4'h8;
      phases = 4'h8;
      tick(10);
      resetn = 1'b1;
      tick(3);
      `CHK("max", max_phase_cnt, 4'h8)
      `CHK("gains", current_balance_gain, {8{5'h0f}})
      rd(8'h0e, 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         wr(8'h0e, ot[i][14:7]);
         `CHK("offset", ofs_out, ot[i][6:0])
         rd(8'h0e, ot[i][14:7]);
      end
      gx = {8{5'h0f}};
      for (int i = 0; i < 8; i++)
      begin
         g = 5'(i * 9);
         gx[5 * i +: 5] = g;
         wr(8'h40 + 8'(i), {3'h0, g});
         rd(8'h40 + 8'(i), {3'h0, g});
      end
      `CHK("gains", current_balance_gain, gx)
      // each count refreshes the latch; requests cross the limit both ways
      for (int n = 1; n < 9; n++)
      begin
         phases = 4'(n);
         req_phase_cnt = 4'(9 - n);
         tick(4);
         detect_start = 1'b1;
         tick(8);
         detect_start = 1'b0;
         tick(2);
         mk = ~(8'hfe << n);
         ex = 8'h01 << n;
         `CHK("max", max_phase_cnt, 4'(n))
         `CHK("disabled", phase_disabled & mk, ex)
         `CHK("active", active_phase_cnt, 4'(n < 9 - n ? n : 9 - n))
      end
      req_phase_cnt = 4'h0;
      tick(2);
      `CHK("active", active_phase_cnt, 4'h1)
      rd(8'h20, 8'h00);
      wr(8'h48, 8'h03);
      rd(8'h48, 8'h08);
      end_sim(0);
   end
endmodule
